/* File: core/dma_channel_control_word.sv */
module dma_channel_control_word (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Channel control
    input wire logic chanEnable,
    input wire logic useAltStart,
    input wire logic chanRequest,
    input wire logic scatterGather,
    input wire logic grant,
    // Data mover
    output logic xferStrobe,
    output logic [1:0] xferSize,
    input wire logic xferDone,
    // Status
    output logic arbRequest,
    output logic cycleDone,
    output logic burstOnlySet,
    output logic busy,
    // SRAM pins
    output logic memRd,
    output logic memWr,
    output logic memAlt,
    output logic [31:0] memWrData,
    input wire logic [31:0] memRdData,
    input wire logic memAck
);
    typedef enum logic [2:0] {IDLE, FETCH, MOVE, WBACK, ARB} state_type;

    state_type state_q, state_d;
    logic [31:0] word_q;
    logic [10:0] left_q;
    logic [10:0] burstCnt_q;
    logic alt_q;
    logic pend_q;
    logic doneP_q;
    logic burstP_q;
    logic reqSync1_q, reqSync2_q, reqPrev_q;
    logic [31:0] wbWord;
    logic [2:0] fetchedMode, curMode;
    logic [10:0] burstLen, fetchedCount;
    logic freshReq, lastXfer, burstEnd;
    logic takeReq, cycleStart;
    logic resume_q;

    sram_port_if mem ();

    sram_port_mux i_sram_port_mux (
        .eng(mem.port),
        .memRd(memRd),
        .memWr(memWr),
        .memAlt(memAlt),
        .memWrData(memWrData),
        .memRdData(memRdData),
        .memAck(memAck)
    );

    function automatic logic [10:0] pow2(input logic [3:0] r);
        pow2 = (r > 4'hA) ? 11'h400 : (11'h001 << r);
    endfunction

    assign fetchedMode = mem.rdData[dma_ctl_pkg::MODE_LSB +: dma_ctl_pkg::MODE_W];
    assign fetchedCount = {1'b0, mem.rdData[dma_ctl_pkg::COUNT_LSB +: dma_ctl_pkg::COUNT_W]}
        + 11'h001;
    assign curMode = word_q[dma_ctl_pkg::MODE_LSB +: dma_ctl_pkg::MODE_W];
    assign burstLen = pow2(word_q[dma_ctl_pkg::RPOW_LSB +: dma_ctl_pkg::RPOW_W]);
    assign lastXfer = (left_q == 11'h001);
    assign burstEnd = lastXfer || (burstCnt_q == 11'h001);
    assign freshReq = reqSync2_q && !reqPrev_q;
    assign cycleStart = (state_q == IDLE) && (state_d == FETCH);
    assign takeReq = cycleStart || ((state_q == ARB) && (state_d == FETCH));

    // Write-back image: count, size fix, stop on completion
    always_comb
    begin
        wbWord = word_q;
        wbWord[dma_ctl_pkg::COUNT_LSB +: dma_ctl_pkg::COUNT_W] =
            (left_q == 11'h000) ? 10'h000 : 10'(left_q - 11'h001);
        wbWord[dma_ctl_pkg::DSTSZ_LSB +: dma_ctl_pkg::SIZE_W] =
            word_q[dma_ctl_pkg::SRCSZ_LSB +: dma_ctl_pkg::SIZE_W];
        if (left_q == 11'h000)
        begin
            wbWord[dma_ctl_pkg::MODE_LSB +: dma_ctl_pkg::MODE_W] = dma_ctl_pkg::MODE_STOP;
        end
    end

    assign mem.rdReq = (state_q == FETCH);
    assign mem.wrReq = (state_q == WBACK);
    assign mem.alt = alt_q;
    assign mem.wrData = wbWord;
    assign xferStrobe = (state_q == MOVE);
    assign xferSize = word_q[dma_ctl_pkg::SRCSZ_LSB +: dma_ctl_pkg::SIZE_W];
    assign arbRequest = (state_q == ARB);
    assign busy = (state_q != IDLE);
    assign cycleDone = doneP_q;
    assign burstOnlySet = burstP_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            IDLE:
                if (chanEnable && (pend_q || freshReq))
                begin
                    state_d = FETCH;
                end
            FETCH:
                if (mem.ack)
                begin
                    state_d = (fetchedMode == dma_ctl_pkg::MODE_STOP ||
                               fetchedMode > dma_ctl_pkg::MODE_PINGPONG) ? IDLE : MOVE;
                end
            MOVE:
                if (xferDone && burstEnd)
                begin
                    state_d = WBACK;
                end
            WBACK:
                if (mem.ack)
                begin
                    if (left_q == 11'h000)
                    begin
                        state_d = (curMode == dma_ctl_pkg::MODE_PINGPONG) ? FETCH : IDLE;
                    end
                    else
                    begin
                        state_d = ARB;
                    end
                end
            ARB:
                if (grant)
                begin
                    if (curMode == dma_ctl_pkg::MODE_AUTO)
                    begin
                        state_d = FETCH;
                    end
                    else if (pend_q || freshReq)
                    begin
                        state_d = FETCH;
                    end
                    else
                    begin
                        state_d = IDLE;
                    end
                end
            default:
                state_d = IDLE;
        endcase
        if (!chanEnable)
        begin
            state_d = IDLE;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reqSync1_q <= 1'b0;
            reqSync2_q <= 1'b0;
            reqPrev_q <= 1'b0;
        end
        else
        begin
            reqSync1_q <= chanRequest;
            reqSync2_q <= reqSync1_q;
            reqPrev_q <= reqSync2_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q <= IDLE;
            pend_q <= 1'b0;
            resume_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // A request that starts a fetch is used up; a second one waits
            pend_q <= takeReq ? (pend_q && freshReq) : (pend_q || freshReq);
            // Cycle paused in IDLE after a grant with no request pending keeps its structure
            resume_q <= chanEnable &&
                ((state_q == ARB) ? (state_d == IDLE) : (resume_q && !cycleStart));
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            word_q <= dma_ctl_pkg::WORD_RESET;
            left_q <= dma_ctl_pkg::COUNT_RESET;
            burstCnt_q <= dma_ctl_pkg::COUNT_RESET;
            alt_q <= 1'b0;
        end
        else
        begin
            if (cycleStart && !resume_q)
            begin
                alt_q <= useAltStart;
            end
            if (state_q == FETCH && mem.ack)
            begin
                word_q <= mem.rdData;
                left_q <= fetchedCount;
                burstCnt_q <= pow2(mem.rdData[dma_ctl_pkg::RPOW_LSB +: dma_ctl_pkg::RPOW_W]);
            end
            if (state_q == MOVE && xferDone)
            begin
                left_q <= left_q - 11'h001;
                burstCnt_q <= burstCnt_q - 11'h001;
            end
            if (state_q == WBACK && mem.ack)
            begin
                word_q <= wbWord;
                burstCnt_q <= burstLen;
                if (left_q == 11'h000 && curMode == dma_ctl_pkg::MODE_PINGPONG)
                begin
                    alt_q <= !alt_q;
                end
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            doneP_q <= 1'b0;
            burstP_q <= 1'b0;
        end
        else
        begin
            doneP_q <= (state_q == WBACK) && mem.ack && (left_q == 11'h000);
            burstP_q <= (state_q == WBACK) && mem.ack && (left_q == 11'h000) && alt_q &&
                scatterGather && word_q[dma_ctl_pkg::BURST_BIT];
        end
    end
endmodule

/* File: include/dma_ctl_pkg.sv */
package dma_ctl_pkg;
    localparam int WORD_W = 32;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int BURST_BIT = 3;
    localparam int COUNT_LSB = 4;
    localparam int COUNT_W = 10;
    localparam int RPOW_LSB = 14;
    localparam int RPOW_W = 4;
    localparam int DSTSZ_LSB = 30;
    localparam int SRCSZ_LSB = 24;
    localparam int SIZE_W = 2;
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [2:0] MODE_BASIC = 3'h1;
    localparam logic [2:0] MODE_AUTO = 3'h2;
    localparam logic [2:0] MODE_PINGPONG = 3'h3;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [10:0] COUNT_RESET = 11'h000;
endpackage

/* File: include/sram_port_if.sv */
interface sram_port_if;
    logic rdReq;
    logic wrReq;
    logic alt;
    logic [31:0] wrData;
    logic [31:0] rdData;
    logic ack;
    modport engine (output rdReq, wrReq, alt, wrData, input rdData, ack);
    modport port (input rdReq, wrReq, alt, wrData, output rdData, ack);
endinterface

/* File: core/sram_port_mux.sv */
module sram_port_mux (
    // Engine side
    sram_port_if.port eng,
    // SRAM pins
    output logic memRd,
    output logic memWr,
    output logic memAlt,
    output logic [31:0] memWrData,
    input wire logic [31:0] memRdData,
    input wire logic memAck
);
    assign memRd = eng.rdReq;
    assign memWr = eng.wrReq;
    assign memAlt = eng.alt;
    assign memWrData = eng.wrData;
    assign eng.rdData = memRdData;
    assign eng.ack = memAck;
endmodule

/* File: testbench/dma_ctl_checker_sva.sv */
module dma_ctl_checker (
    // Watched ports
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic grant,
    input wire logic xferStrobe,
    input wire logic arbRequest,
    input wire logic cycleDone,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [31:0] memWrData,
    input wire logic [31:0] memRdData,
    input wire logic memAck
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    fetch_first_a: assert property ($rose(xferStrobe) |-> $past(memRd && memAck))
        else $error("move without fetch");
    burst_wback_a: assert property ($fell(xferStrobe) |-> memWr)
        else $error("no write-back");
    dst_size_a: assert property (memWr |-> memWrData[31:30] == memWrData[25:24])
        else $error("dst size kept");
    done_stop_a: assert property (cycleDone |->
        $past(memWr && memAck && memWrData[2:0] == 3'h0)) else $error("done without stop");
    arb_wback_a: assert property ($rose(arbRequest) |-> $past(memWr && memAck))
        else $error("arbitration before write-back");
    stop_idle_a: assert property (memRd && memAck && memRdData[2:0] == 3'h0
        |=> !xferStrobe && !memWr) else $error("stop word used");
    auto_fetch_a: assert property (arbRequest && grant && memWrData[2:0] == 3'h2
        |=> memRd) else $error("auto request missing");
    read_hold_a: assert property (memRd && !memAck |=> memRd)
        else $error("read dropped");
endmodule
bind dma_channel_control_word dma_ctl_checker i_dma_ctl_checker (.*);

/* File: testbench/sram_model.sv */
module sram_model (
    // Engine side
    input wire logic ref_clk,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic memAlt,
    input wire logic [31:0] memWrData,
    output logic [31:0] memRdData,
    output logic memAck,
    // Answer delay in cycles
    input wire logic [1:0] slowWait
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [2];
    logic [31:0] lastRd = 32'h0;
    logic [1:0] waitCnt = 2'h0;
    initial memAck = 1'b0;
    initial memRdData = 32'hFFFFFFFF;
    always @(posedge ref_clk)
    begin
        memAck <= 1'b0;
        // Idle bus shows the inverse of the last read
        memRdData <= ~lastRd;
        if ((memRd || memWr) && !memAck)
        begin
            waitCnt <= (waitCnt == 2'h0) ? slowWait : waitCnt - 2'h1;
            memAck <= (waitCnt == 2'h0);
            if (waitCnt == 2'h0 && memWr)
                mem[memAlt] <= memWrData;
            if (waitCnt == 2'h0 && !memWr)
            begin
                memRdData <= mem[memAlt];
                lastRd <= mem[memAlt];
            end
        end
    end
endmodule

/* File: testbench/dma_channel_control_word_bench.sv */
module dma_channel_control_word_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chanEnable = 1'b0, useAltStart = 1'b0, chanRequest = 1'b0, reqArm = 1'b0;
    logic scatterGather = 1'b0, grant = 1'b0, xferDone = 1'b0;
    logic [1:0] slowWait = 2'h0, expSize = 2'h0, xferSize;
    logic expBurst = 1'b0;
    logic xferStrobe, arbRequest, cycleDone, burstOnlySet, busy, memRd, memWr, memAlt, memAck;
    logic [31:0] memWrData, memRdData;
    logic [31:0] expQ [$];
    int seed = 4562, num_errors = 0, comparisons = 0, xfers = 0, doneCnt = 0;
    dma_channel_control_word i_dma_channel_control_word (.*);
    sram_model i_sram_model (.*);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d of %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Queue the write-backs one structure should produce
    task automatic plan(input logic [31:0] w, inout int n);
        int left = int'(w[13:4]) + 1;
        int b = 1 << w[17:14];
        n += left;
        w[31:30] = w[25:24];
        while (left > 0)
        begin
            left -= (left < b) ? left : b;
            w[13:4] = (left > 0) ? 10'(left - 1) : 10'h000;
            w[2:0] = (left > 0) ? w[2:0] : 3'h0;
            expQ.push_back(w);
        end
    endtask
    task automatic pulse();
        chanRequest = 1'b1;
        repeat (3) @(negedge ref_clk);
        chanRequest = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask
    always @(negedge ref_clk)
    begin
        grant <= 1'($random(seed));
        scatterGather <= 1'($random(seed));
        slowWait <= 2'($random(seed));
        xferDone <= xferStrobe && !xferDone && 1'($random(seed));
    end
    always @(posedge ref_clk)
    begin
        if (xferDone === 1'b1)
        begin
            xfers++;
            check("xferSize", 32'(xferSize), 32'(expSize));
        end
        doneCnt += int'(cycleDone === 1'b1);
        if (memWr === 1'b1 && memAck === 1'b1)
            check("wb", memWrData, expQ.size() ? expQ.pop_front() : 'x);
        if (sys_rst === 1'b0)
            check("burstOnlySet", 32'(burstOnlySet), 32'(expBurst));
        // Completing write-back of the alternate structure during scatter-gather
        expBurst = (memWr === 1'b1) && (memAck === 1'b1) && (memWrData[2:0] === 3'h0) &&
            (memAlt === 1'b1) && (scatterGather === 1'b1) && (memWrData[3] === 1'b1);
    end
    initial forever
    begin
        @(negedge ref_clk);
        if (arbRequest === 1'b1 && reqArm)
            pulse();
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        logic [31:0] w;
        int n;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        chanEnable = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            w = $random(seed);
            w[2:0] = 3'(i % 4);
            w[17:4] = {4'(i % 3), 10'($unsigned($random(seed)) % 8)};
            useAltStart = (i % 4 == 3) ? 1'b0 : 1'($random(seed));
            i_sram_model.mem[useAltStart] = w;
            i_sram_model.mem[!useAltStart] = {w[31:14], 10'(i), w[3:0]};
            expSize = w[25:24];
            reqArm = (w[2:0] != dma_ctl_pkg::MODE_AUTO);
            n = 0;
            xfers = 0;
            doneCnt = 0;
            if (w[2:0] != dma_ctl_pkg::MODE_STOP)
                plan(w, n);
            if (w[2:0] == dma_ctl_pkg::MODE_PINGPONG)
                plan(i_sram_model.mem[1], n);
            pulse();
            for (int k = 0; k < 3000 && (busy !== 1'b0 || expQ.size() > 0); k++)
                @(negedge ref_clk);
            repeat (8) @(negedge ref_clk);
            check("pending", 32'(expQ.size()), 0);
            check("transfers", xfers, n);
            if (w[2:0] == dma_ctl_pkg::MODE_PINGPONG)
                check("alt", 32'(i_sram_model.mem[1][2:0]), 0);
            else
                check("cycleDone", doneCnt, 32'(w[2:0] != 3'h0));
        end
        print_verdict();
    end
endmodule
